// ===== core/olfl_ola_cnt.sv
`timescale 1ns/100ps
`default_nettype none
module olfl_ola_cnt
  import olfl_pkg::*;
#(
  parameter int MISSES = OLFL_OLA_MISSES
) (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic clear,
  input  wire logic enable,
  input  wire logic pulse_end,
  input  wire logic overshoot,
  output var  logic open_seen
);

  logic [3:0] misses;

  // ****************************************************************
  // Consecutive-miss counter
  // ****************************************************************
  // A single good pulse restarts the count, so one noisy PWM cycle
  // cannot report an open load on its own.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      misses    <= 4'h0;
      open_seen <= 1'b0;
    end else if (clear || !enable) begin
      misses    <= 4'h0;
      open_seen <= 1'b0;
    end else if (pulse_end) begin
      if (overshoot) begin // [RULE_15]
        misses    <= 4'h0;
        open_seen <= 1'b0;
      end else if (misses < 4'(MISSES)) begin // [RULE_13]
        misses    <= misses + 4'h1;
        open_seen <= (misses + 4'h1) >= 4'(MISSES); // [RULE_15]
      end
    end
  end

endmodule : olfl_ola_cnt
`default_nettype wire

// ===== core/olfl_pkg.sv
package olfl_pkg;

  // ****************************************************************
  // Clock and timing
  // ****************************************************************
  localparam int OLFL_CLK_MHZ       = 250;
  localparam int OLFL_OLP_SHORT_US  = 300;
  localparam int OLFL_OLP_LONG_US   = 1200;
  localparam int OLFL_OLA_MISSES    = 3;
  localparam int OLFL_TCNT_W        = 20;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam int OLFL_AW            = 8;
  localparam logic [7:0] OLFL_CTRL_ADDR = 8'h00;
  localparam logic [7:0] OLFL_STAT_ADDR = 8'h04;

  localparam int OLFL_CTRL_REQ      = 0;
  localparam int OLFL_CTRL_ACT_EN   = 1;
  localparam int OLFL_CTRL_DLY      = 2;
  localparam int OLFL_CTRL_TRSEL    = 3;
  localparam int OLFL_CTRL_CLR      = 4;

  localparam int OLFL_STAT_FAULT    = 0;
  localparam int OLFL_STAT_OPEN1    = 1;
  localparam int OLFL_STAT_OPEN2    = 2;
  localparam int OLFL_STAT_OTEMP    = 3;
  localparam int OLFL_STAT_ACTOPEN  = 4;
  localparam int OLFL_STAT_BUSY     = 5;
  localparam int OLFL_STAT_BRIDGE   = 6;

  // ****************************************************************
  // Control modes and sequencer states
  // ****************************************************************
  localparam logic [1:0] OLFL_MODE_INDEP = 2'h2;

  typedef enum logic [1:0] {
    PT_IDLE   = 2'b00,
    PT_PULLUP = 2'b01,
    PT_PULLDN = 2'b10
  } olfl_pt_state_t;

  typedef struct packed {
    logic thermal_recovery_sel;
    logic passive_test_delay_sel;
    logic active_test_enable;
    logic passive_test_request;
  } olfl_ctrl_t;

  typedef struct packed {
    logic [1:0] pulldown_comparator;
    logic [1:0] pullup_comparator;
    logic [1:0] mode_sel;
    logic       pwm_pulse_end;
    logic       overshoot_det;
    logic       overtemp_det;
    logic       motor_energized;
    logic       open_load_off_pin_n;
    logic       disable_pin;
    logic       sleep_pin_n;
  } olfl_pins_t;

  localparam int OLFL_PINS_W = 13;

endpackage : olfl_pkg

// ===== core/olfl_sync.sv
`timescale 1ns/100ps
`default_nettype none
module olfl_sync #(
  parameter int W = 1
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [W-1:0] async_in,
  output var  logic [W-1:0] sync_out
);

  logic [W-1:0] stage1;

  // ****************************************************************
  // Two flops per bit; the first stage feeds only the second.
  // ****************************************************************
  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        stage1[i]   <= 1'b0;
        sync_out[i] <= 1'b0;
      end else begin
        stage1[i]   <= async_in[i];
        sync_out[i] <= stage1[i];
      end
    end
  end

endmodule : olfl_sync
`default_nettype wire

// ===== core/olfl_top.sv
`timescale 1ns/100ps
`default_nettype none
// Function
// [RULE_01] Open load latches fault low until cleared
// [RULE_02] Delay select picks short or long test
// [RULE_03] Passive test in all modes, bridge off
// [RULE_04] Pin variant runs test at wake unless disabled
// [RULE_05] Host raises disable, waits, then requests test
// [RULE_06] Request bit returns to zero after duration
// [RULE_07] Request bit holds written value until done
// [RULE_08] Disable falling aborts test, no fault
// [RULE_09] No passive test while motor energized
// [RULE_10] Pull-up phase then pull-down phase
// [RULE_11] Both comparators open latch flags, pump runs
// [RULE_12] Clear-faults resets both output open flags
// [RULE_13] No overshoot between switch edges means open
// [RULE_14] Active test off until enable bit written
// [RULE_15] Three consecutive misses report; good pulse restarts
// [RULE_16] Pin variant: off pin gates both tests
// [RULE_17] Host avoids active test with low-side braking
// [RULE_18] Phase/enable and PWM use high-side recirculation
// [RULE_19] Overtemp disables bridge, latches flags, pump runs
// [RULE_20] Recovery select zero: wait for clear command
// [RULE_21] Recovery select one: resume, flag stays latched
// [RULE_22] Sleep pin low sleeps, rising wakes
// [RULE_23] Fault output low whenever fault present
// [RULE_24] Clear keeps flags whose cause persists
module olfl_top
  import olfl_pkg::*;
#(
  parameter bit PIN_VARIANT = 1'b0,
  parameter int PT_SHORT_CYC = OLFL_OLP_SHORT_US * OLFL_CLK_MHZ,
  parameter int PT_LONG_CYC  = OLFL_OLP_LONG_US * OLFL_CLK_MHZ
) (
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [olfl_pkg::OLFL_AW-1:0] paddr,
  input  wire logic [31:0]               pwdata,
  output var  logic [31:0]               prdata,
  output var  logic                      pready,
  output var  logic                      pslverr,
  input  wire logic                      sleep_pin_n,
  input  wire logic                      disable_pin,
  input  wire logic                      open_load_off_pin_n,
  input  wire logic [1:0]                mode_sel,
  input  wire logic                      motor_energized,
  input  wire logic                      overtemp_det,
  input  wire logic                      overshoot_det,
  input  wire logic                      pwm_pulse_end,
  input  wire logic [1:0]                pullup_comparator,
  input  wire logic [1:0]                pulldown_comparator,
  output var  logic                      pullup_src_en,
  output var  logic                      pulldown_src_en,
  output var  logic                      bridge_enable,
  output var  logic                      charge_pump_en,
  output var  logic                      high_side_recirc,
  output var  logic                      fault_out_n_o,
  output var  logic                      fault_out_n_oe
);
  import olfl_pkg::*;

  // ****************************************************************
  // Input synchronisation
  // ****************************************************************
  olfl_pins_t pins_raw;
  olfl_pins_t pins;
  logic [OLFL_PINS_W-1:0] pins_sync;

  always_comb begin
    pins_raw.sleep_pin_n         = sleep_pin_n;
    pins_raw.disable_pin         = disable_pin;
    pins_raw.open_load_off_pin_n = open_load_off_pin_n;
    pins_raw.motor_energized     = motor_energized;
    pins_raw.overtemp_det        = overtemp_det;
    pins_raw.overshoot_det       = overshoot_det;
    pins_raw.pwm_pulse_end       = pwm_pulse_end;
    pins_raw.mode_sel            = mode_sel;
    pins_raw.pullup_comparator   = pullup_comparator;
    pins_raw.pulldown_comparator = pulldown_comparator;
  end

  olfl_sync #(
    .W (OLFL_PINS_W)
  ) u_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in (pins_raw),
    .sync_out (pins_sync)
  );

  assign pins = olfl_pins_t'(pins_sync);

  // ****************************************************************
  // Sleep and wake
  // ****************************************************************
  logic awake;
  logic awake_d;
  logic waking;
  logic pulse_end_d;
  logic pulse_end_rise;

  assign awake = pins.sleep_pin_n; // [RULE_22]

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      awake_d     <= 1'b0;
      pulse_end_d <= 1'b0;
    end else begin
      awake_d     <= awake;
      pulse_end_d <= pins.pwm_pulse_end;
    end
  end

  assign waking         = awake && !awake_d; // [RULE_22]
  assign pulse_end_rise = pins.pwm_pulse_end && !pulse_end_d;

  // ****************************************************************
  // APB slave
  // ****************************************************************
  localparam logic TRSEL_RST = PIN_VARIANT;

  olfl_ctrl_t ctrl;
  logic       apb_setup;
  logic       apb_write;
  logic       addr_ctrl;
  logic       addr_stat;
  logic       clear_faults_bit;
  logic [31:0] stat_word;
  logic [31:0] ctrl_word;

  assign apb_setup = psel && !penable;
  assign apb_write = psel && penable && pready && pwrite;
  assign addr_ctrl = paddr == OLFL_CTRL_ADDR;
  assign addr_stat = paddr == OLFL_STAT_ADDR;
  assign clear_faults_bit = apb_write && addr_ctrl
                            && pwdata[OLFL_CTRL_CLR];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= apb_setup;
      pslverr <= apb_setup && !addr_ctrl && !addr_stat;
      if (apb_setup && !pwrite) begin
        prdata <= addr_ctrl ? ctrl_word :
                  addr_stat ? stat_word : 32'h0000_0000;
      end else begin
        prdata <= 32'h0000_0000;
      end
    end
  end

  // ****************************************************************
  // Passive test sequencer
  // ****************************************************************
  olfl_pt_state_t pt_state;
  logic [OLFL_TCNT_W-1:0] pt_timer;
  logic [OLFL_TCNT_W-1:0] phase_len;
  logic [1:0] pu_hit;
  logic       pt_busy;
  logic       pt_allowed;
  logic       pt_start;
  logic       pt_abort;
  logic       pt_phase_end;
  logic       pt_done;
  logic       pin_pending;
  logic [1:0] open_found;

  // Each phase takes half of the selected test duration.
  assign phase_len = ctrl.passive_test_delay_sel ?
                     OLFL_TCNT_W'(PT_LONG_CYC / 2) :
                     OLFL_TCNT_W'(PT_SHORT_CYC / 2); // [RULE_02]

  assign pt_busy    = pt_state != PT_IDLE;
  assign pt_allowed = PIN_VARIANT ? !pins.open_load_off_pin_n : 1'b1;
  // The serial variant runs only while the host holds disable_pin high.
  assign pt_start   = awake && pt_state == PT_IDLE
                      && !pins.motor_energized // [RULE_09]
                      && (PIN_VARIANT ? (pin_pending && pt_allowed)
                          : (ctrl.passive_test_request
                             && pins.disable_pin)); // [RULE_05]
  assign pt_abort   = pt_busy && (pins.motor_energized
                      || (!PIN_VARIANT && !pins.disable_pin)); // [RULE_08]
  assign pt_phase_end = pt_busy && pt_timer == OLFL_TCNT_W'(0);
  assign pt_done    = pt_state == PT_PULLDN && pt_phase_end && !pt_abort;

  for (genvar i = 0; i < 2; i++) begin : g_open
    assign open_found[i] = pt_done && pu_hit[i]
                           && pins.pulldown_comparator[i]; // [RULE_11]
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pt_state <= PT_IDLE;
      pt_timer <= OLFL_TCNT_W'(0);
      pu_hit   <= 2'h0;
    end else if (!awake || pt_abort) begin
      pt_state <= PT_IDLE; // [RULE_08]
      pt_timer <= OLFL_TCNT_W'(0);
      pu_hit   <= 2'h0;
    end else begin
      unique case (pt_state)
        PT_IDLE: begin
          if (pt_start) begin
            pt_state <= PT_PULLUP; // [RULE_10]
            pt_timer <= phase_len - OLFL_TCNT_W'(1);
          end
        end
        PT_PULLUP: begin
          if (pt_phase_end) begin
            pu_hit   <= pins.pullup_comparator; // [RULE_10]
            pt_state <= PT_PULLDN;
            pt_timer <= phase_len - OLFL_TCNT_W'(1);
          end else begin
            pt_timer <= pt_timer - OLFL_TCNT_W'(1);
          end
        end
        PT_PULLDN: begin
          if (pt_phase_end) begin
            pt_state <= PT_IDLE;
          end else begin
            pt_timer <= pt_timer - OLFL_TCNT_W'(1);
          end
        end
        default: begin
          pt_state <= PT_IDLE;
        end
      endcase
    end
  end

  // In the pin variant, a pending run is armed at reset and at every wake from sleep.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_pending <= PIN_VARIANT;
    end else if (waking) begin
      pin_pending <= PIN_VARIANT; // [RULE_04]
    end else if (pt_start || (awake && !pt_allowed)) begin
      pin_pending <= 1'b0; // [RULE_04]
    end
  end

  // ****************************************************************
  // Control register
  // ****************************************************************
  // Sleep returns the control bits to their reset values.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= '{thermal_recovery_sel: TRSEL_RST, default: 1'b0};
    end else if (!awake) begin
      ctrl <= '{thermal_recovery_sel: TRSEL_RST, default: 1'b0};
    end else begin
      if (apb_write && addr_ctrl) begin
        ctrl.active_test_enable     <= pwdata[OLFL_CTRL_ACT_EN]; // [RULE_14]
        ctrl.passive_test_delay_sel <= pwdata[OLFL_CTRL_DLY];
        ctrl.thermal_recovery_sel   <= pwdata[OLFL_CTRL_TRSEL];
      end
      // Once running, the request keeps its value until the test ends.
      if (pt_busy && (pt_done || pt_abort)) begin
        ctrl.passive_test_request <= 1'b0; // [RULE_06]
      end else if (apb_write && addr_ctrl && !pt_busy) begin
        ctrl.passive_test_request <= pwdata[OLFL_CTRL_REQ]; // [RULE_07]
      end
    end
  end

  // ****************************************************************
  // Active open-load test
  // ****************************************************************
  logic act_enable;
  logic act_open;

  assign act_enable = PIN_VARIANT ? !pins.open_load_off_pin_n // [RULE_16]
                      : ctrl.active_test_enable; // [RULE_14]

  olfl_ola_cnt #(
    .MISSES (OLFL_OLA_MISSES)
  ) u_ola (
    .pclk      (pclk),
    .presetn   (presetn),
    .clear     (!awake),
    .enable    (act_enable && bridge_enable),
    .pulse_end (pulse_end_rise),
    .overshoot (pins.overshoot_det),
    .open_seen (act_open)
  );

  // ****************************************************************
  // Fault flags
  // ****************************************************************
  logic [1:0] output_open_flag;
  logic       act_open_flag;
  logic       overtemp_flag;
  logic       tsd_shutdown;
  logic       any_fault;

  // Set beats clear, and a clear leaves act_open_flag and overtemp_flag set while their cause remains.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      output_open_flag <= 2'h0;
      act_open_flag    <= 1'b0;
      overtemp_flag    <= 1'b0;
    end else if (!awake) begin
      output_open_flag <= 2'h0; // [RULE_01]
      act_open_flag    <= 1'b0;
      overtemp_flag    <= 1'b0;
    end else begin
      if (clear_faults_bit) begin
        output_open_flag <= open_found; // [RULE_12]
      end else begin
        output_open_flag <= output_open_flag | open_found; // [RULE_01]
      end
      if (act_open) begin
        act_open_flag <= 1'b1; // [RULE_15]
      end else if (clear_faults_bit) begin
        act_open_flag <= 1'b0; // [RULE_24]
      end
      if (pins.overtemp_det) begin
        overtemp_flag <= 1'b1; // [RULE_19]
      end else if (clear_faults_bit) begin
        overtemp_flag <= 1'b0; // [RULE_21]
      end
    end
  end

  // Thermal protection has no enable; only recovery is selectable.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tsd_shutdown <= 1'b0;
    end else if (!awake) begin
      tsd_shutdown <= 1'b0;
    end else if (pins.overtemp_det) begin
      tsd_shutdown <= 1'b1; // [RULE_19]
    end else if (ctrl.thermal_recovery_sel) begin
      tsd_shutdown <= 1'b0; // [RULE_21]
    end else if (clear_faults_bit) begin
      tsd_shutdown <= 1'b0; // [RULE_20]
    end
  end

  assign any_fault = |output_open_flag || act_open_flag || tsd_shutdown
                     || (overtemp_flag && !ctrl.thermal_recovery_sel);

  // ****************************************************************
  // Status word and control readback
  // ****************************************************************
  always_comb begin
    stat_word = 32'h0000_0000;
    stat_word[OLFL_STAT_FAULT]   = any_fault;
    stat_word[OLFL_STAT_OPEN1]   = output_open_flag[0];
    stat_word[OLFL_STAT_OPEN2]   = output_open_flag[1];
    stat_word[OLFL_STAT_OTEMP]   = overtemp_flag;
    stat_word[OLFL_STAT_ACTOPEN] = act_open_flag;
    stat_word[OLFL_STAT_BUSY]    = pt_busy;
    stat_word[OLFL_STAT_BRIDGE]  = bridge_enable;
    ctrl_word = 32'h0000_0000;
    ctrl_word[OLFL_CTRL_REQ]     = ctrl.passive_test_request;
    ctrl_word[OLFL_CTRL_ACT_EN]  = ctrl.active_test_enable;
    ctrl_word[OLFL_CTRL_DLY]     = ctrl.passive_test_delay_sel;
    ctrl_word[OLFL_CTRL_TRSEL]   = ctrl.thermal_recovery_sel;
  end

  // ****************************************************************
  // Output drivers
  // ****************************************************************
  // Open-load faults only report; sleep, thermal shutdown and a starting
  // or running passive test are the only things that hold the bridge off here.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pullup_src_en    <= 1'b0;
      pulldown_src_en  <= 1'b0;
      bridge_enable    <= 1'b0;
      charge_pump_en   <= 1'b0;
      high_side_recirc <= 1'b1;
      fault_out_n_o    <= 1'b0;
      fault_out_n_oe   <= 1'b0;
    end else begin
      pullup_src_en    <= pt_state == PT_PULLUP && !pt_abort; // [RULE_10]
      pulldown_src_en  <= pt_state == PT_PULLDN && !pt_abort; // [RULE_10]
      bridge_enable    <= awake && !tsd_shutdown // [RULE_19]
                          && !pt_busy && !pt_start; // [RULE_03]
      charge_pump_en   <= awake; // [RULE_11]
      high_side_recirc <= pins.mode_sel != OLFL_MODE_INDEP; // [RULE_18]
      fault_out_n_o    <= 1'b0;
      fault_out_n_oe   <= any_fault; // [RULE_23]
    end
  end

endmodule : olfl_top
`default_nettype wire

// ===== tb/olfl_load_model.sv
`timescale 1ns/100ps
`default_nettype none
// ********
// Motor load model
// ********
module olfl_load_model (
  input  wire logic       pclk,
  input  wire logic       pullup_src_en,
  input  wire logic       pulldown_src_en,
  input  wire logic [1:0] open_pu,
  input  wire logic [1:0] open_pd,
  input  wire logic       miss,
  output var  logic [1:0] pullup_comparator,
  output var  logic [1:0] pulldown_comparator,
  output var  logic       overshoot_det,
  output var  logic       pwm_pulse_end = 1'b0
);
  logic [3:0] ph = 4'h0;
  // A comparator trips only while its own current source is on.
  assign pullup_comparator   = open_pu & {2{pullup_src_en}};
  assign pulldown_comparator = open_pd & {2{pulldown_src_en}};
  // A lost load gives no freewheel overshoot.
  assign overshoot_det = !miss;
  always_ff @(posedge pclk) begin
    ph <= ph + 4'h1;
    pwm_pulse_end <= ph[3];
  end
endmodule : olfl_load_model
`default_nettype wire

// ===== tb/olfl_top_monitor.sv
`timescale 1ns/100ps
`default_nettype none
// ********
// Fault logic checker
// ********
module olfl_top_monitor
  import olfl_pkg::*;
(
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic       sleep_pin_n,
  input wire logic [1:0] mode_sel,
  input wire logic       motor_energized,
  input wire logic       overtemp_det,
  input wire logic       pullup_src_en,
  input wire logic       pulldown_src_en,
  input wire logic       bridge_enable,
  input wire logic       charge_pump_en,
  input wire logic       high_side_recirc,
  input wire logic       fault_out_n_o,
  input wire logic       fault_out_n_oe
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_test_off;
    pullup_src_en || pulldown_src_en |-> !bridge_enable && charge_pump_en;
  endproperty
  a_test_off: assert property (p_test_off)
    else $error("Bridge on during load test");
  property p_excl;
    !(pullup_src_en && pulldown_src_en);
  endproperty
  a_excl: assert property (p_excl)
    else $error("Both sources on");
  property p_order;
    $rose(pulldown_src_en) |-> $past(pullup_src_en);
  endproperty
  a_order: assert property (p_order)
    else $error("Pull-down phase without pull-up phase");
  property p_energ;
    motor_energized [*4] |-> !pullup_src_en && !pulldown_src_en;
  endproperty
  a_energ: assert property (p_energ)
    else $error("Load test while energized");
  property p_hot;
    $rose(overtemp_det) && charge_pump_en |->
      ##[1:5] (!bridge_enable && fault_out_n_oe && charge_pump_en);
  endproperty
  a_hot: assert property (p_hot)
    else $error("No thermal shutdown");
  property p_sleep;
    !sleep_pin_n [*4] |-> !charge_pump_en && !bridge_enable;
  endproperty
  a_sleep: assert property (p_sleep)
    else $error("Awake while sleep held");
  property p_recirc;
    $stable(mode_sel) [*4] |->
      high_side_recirc == (mode_sel != OLFL_MODE_INDEP);
  endproperty
  a_recirc: assert property (p_recirc)
    else $error("Recirculation mode wrong");
  property p_pin;
    fault_out_n_oe |-> !fault_out_n_o;
  endproperty
  a_pin: assert property (p_pin)
    else $error("Fault pin driven high");
endmodule : olfl_top_monitor
bind olfl_top olfl_top_monitor u_mon (
  .pclk, .presetn, .sleep_pin_n, .mode_sel, .motor_energized,
  .overtemp_det, .pullup_src_en, .pulldown_src_en, .bridge_enable,
  .charge_pump_en, .high_side_recirc, .fault_out_n_o, .fault_out_n_oe
);
`default_nettype wire

// ===== tb/testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import olfl_pkg::*;
  localparam int SHORT = 40;
  localparam int LONG = 80;
  localparam logic [7:0] C = OLFL_CTRL_ADDR;
  localparam logic [7:0] S = OLFL_STAT_ADDR;
  localparam logic [31:0] A = 32'hFFFFFFFF;
  localparam logic [31:0] M = 32'h0000003F;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, q;
  logic        sleep_pin_n, disable_pin, motor_energized, overtemp_det;
  logic        overshoot_det, pwm_pulse_end, miss, bridge_enable;
  logic [1:0]  mode_sel, pullup_comparator, pulldown_comparator;
  logic [1:0]  open_pu, open_pd;
  logic        pullup_src_en, pulldown_src_en, charge_pump_en;
  logic        high_side_recirc, fault_out_n_o, fault_out_n_oe;
  int          n_mismatch, total_checks, cyc;
  olfl_top #(.PT_SHORT_CYC(SHORT), .PT_LONG_CYC(LONG)) DUT (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .sleep_pin_n, .disable_pin,
    .open_load_off_pin_n(1'b1), .mode_sel, .motor_energized,
    .overtemp_det, .overshoot_det, .pwm_pulse_end, .pullup_comparator,
    .pulldown_comparator, .pullup_src_en, .pulldown_src_en,
    .bridge_enable, .charge_pump_en, .high_side_recirc, .fault_out_n_o,
    .fault_out_n_oe
  );
  olfl_load_model u_load (
    .pclk, .pullup_src_en, .pulldown_src_en, .open_pu, .open_pd, .miss,
    .pullup_comparator, .pulldown_comparator, .overshoot_det,
    .pwm_pulse_end
  );
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  task automatic tally_and_finish;
    $display("Checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : tally_and_finish
  // A hung handshake or pulse wait ends here as a mismatch.
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 6000) begin
      n_mismatch++;
      tally_and_finish;
    end
  end
  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask : tick
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] m,
                    input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(q & m, e);
  endtask : rd
  // Miss is changed well clear of a pulse end, so the two synced inputs
  // never disagree about which pulse it belongs to.
  task automatic pulses(input int n, input logic m);
    miss <= m;
    repeat (n) @(posedge pwm_pulse_end);
    tick(4);
  endtask : pulses
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, disable_pin} = '0;
    {motor_energized, overtemp_det, miss, mode_sel, open_pu, open_pd} = '0;
    sleep_pin_n = 1'b1;
    tick(12);
    presetn <= 1'b1;
    tick(6);
    rd(C, A, 32'h0);
    rd(S, A, 32'h40);
    rd(8'h08, A, 32'h0);
    chk({31'h0, err}, 32'h1);
    disable_pin <= 1'b1;
    tick(4);
    wr(C, 32'h1);
    rd(C, A, 32'h1);
    rd(S, M, 32'h20);
    tick(SHORT + 8);
    rd(C, A, 32'h0);
    rd(S, M, 32'h0);
    open_pu <= 2'b11;
    open_pd <= 2'b01;
    wr(C, 32'h5);
    tick(LONG / 2);
    rd(C, A, 32'h5);
    tick(LONG / 2 + 8);
    rd(C, A, 32'h4);
    rd(S, M, 32'h3);
    chk({31'h0, fault_out_n_oe}, 32'h1);
    wr(C, 32'h14);
    rd(S, M, 32'h0);
    wr(C, 32'h1);
    tick(28);
    disable_pin <= 1'b0;
    tick(6);
    rd(C, A, 32'h0);
    rd(S, M, 32'h0);
    disable_pin <= 1'b1;
    motor_energized <= 1'b1;
    tick(4);
    wr(C, 32'h1);
    tick(SHORT + 8);
    rd(S, M, 32'h0);
    open_pu <= 2'b00;
    open_pd <= 2'b00;
    motor_energized <= 1'b0;
    tick(SHORT + 8);
    disable_pin <= 1'b0;
    mode_sel <= 2'h1;
    pulses(3, 1'b1);
    rd(S, M, 32'h0);
    wr(C, 32'h2);
    pulses(1, 1'b0);
    pulses(2, 1'b1);
    pulses(1, 1'b0);
    pulses(2, 1'b1);
    rd(S, M, 32'h0);
    pulses(1, 1'b1);
    rd(S, M, 32'h11);
    pulses(1, 1'b0);
    wr(C, 32'h12);
    rd(S, M, 32'h0);
    wr(C, 32'h0);
    overtemp_det <= 1'b1;
    tick(8);
    rd(S, A, 32'h9);
    wr(C, 32'h10);
    rd(S, A, 32'h9);
    overtemp_det <= 1'b0;
    tick(8);
    rd(S, A, 32'h9);
    wr(C, 32'h10);
    tick(2);
    rd(S, A, 32'h40);
    wr(C, 32'h8);
    overtemp_det <= 1'b1;
    tick(8);
    rd(S, 32'h48, 32'h8);
    overtemp_det <= 1'b0;
    tick(8);
    rd(S, 32'h48, 32'h48);
    chk({31'h0, fault_out_n_oe}, 32'h0);
    wr(C, 32'h18);
    tick(2);
    rd(S, A, 32'h40);
    overtemp_det <= 1'b1;
    mode_sel <= OLFL_MODE_INDEP;
    tick(8);
    overtemp_det <= 1'b0;
    sleep_pin_n <= 1'b0;
    tick(8);
    sleep_pin_n <= 1'b1;
    mode_sel <= 2'h0;
    tick(8);
    rd(C, A, 32'h0);
    rd(S, A, 32'h40);
    tally_and_finish;
  end
endmodule : testbench
`default_nettype wire
